/* uh_pkg.sv */
// Purpose: shared types and constants for the unsigned packed halving datapath
// Assumes: 32-bit register file words, condition codes in the usual 4-bit form
// Notes: everything the top and both leaves agree on lives here
package uh_pkg;

  // --------------------------------------------------------------------
  // widths and lane layout
  // --------------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int LONG_W = 64;
  localparam int FLAG_W = 4;
  localparam int HALF_LO_POS = 0;
  localparam int HALF_HI_POS = 16;

  // --------------------------------------------------------------------
  // values after reset
  // --------------------------------------------------------------------
  localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
  localparam logic [FLAG_W-1:0] LANE_FLAGS_SET = 4'h3;

  // --------------------------------------------------------------------
  // condition codes; nzcv bit positions
  // --------------------------------------------------------------------
  localparam int FLAG_N_POS = 3;
  localparam int FLAG_Z_POS = 2;
  localparam int FLAG_C_POS = 1;
  localparam int FLAG_V_POS = 0;
  localparam logic [3:0] CC_ZERO_SET = 4'h0;
  localparam logic [3:0] CC_ZERO_CLR = 4'h1;
  localparam logic [3:0] CC_CARRY_SET = 4'h2;
  localparam logic [3:0] CC_CARRY_CLR = 4'h3;
  localparam logic [3:0] CC_NEG_SET = 4'h4;
  localparam logic [3:0] CC_NEG_CLR = 4'h5;
  localparam logic [3:0] CC_OVF_SET = 4'h6;
  localparam logic [3:0] CC_OVF_CLR = 4'h7;
  localparam logic [3:0] CC_UNS_HIGHER = 4'h8;
  localparam logic [3:0] CC_UNS_LOWER_SAME = 4'h9;
  localparam logic [3:0] CC_SIGN_MATCH = 4'ha;
  localparam logic [3:0] CC_SIGN_DIFFER = 4'hb;
  localparam logic [3:0] CC_SIGNED_ABOVE = 4'hc;
  localparam logic [3:0] CC_SIGNED_NOT_ABOVE = 4'hd;
  localparam logic [3:0] CC_ALWAYS_EXECUTE = 4'he;
  localparam logic [3:0] CC_RESERVED = 4'hf;

  // --------------------------------------------------------------------
  // operations
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    unsigned_cross_add_sub = 3'h0,
    halving_add_halfword_lanes = 3'h1,
    halving_add_byte_lanes = 3'h2,
    halving_cross_add_sub = 3'h3,
    halving_sub_halfword_lanes = 3'h4,
    halving_sub_byte_lanes = 3'h5,
    halving_cross_sub_add = 3'h6,
    mul_double_accumulate_long = 3'h7
  } uh_op_t;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    uh_op_t op;
    logic [3:0] cond;
    logic [FLAG_W-1:0] nzcv;
    logic [WORD_W-1:0] first_operand;
    logic [WORD_W-1:0] second_operand;
    logic [WORD_W-1:0] multiplier;
    logic [WORD_W-1:0] low_accum;
    logic [WORD_W-1:0] high_accum;
  } uh_req_t;

  typedef struct packed {
    logic valid;
    logic executed;
    logic wr_low;
    logic wr_high;
    logic flags_wr;
    logic [FLAG_W-1:0] greater_equal_flags;
    logic [WORD_W-1:0] low_result;
    logic [WORD_W-1:0] high_result;
  } uh_rsp_t;

endpackage : uh_pkg

/* uh_lanes.sv */
// Purpose: combinational lane arithmetic for the packed add/subtract operations
// Assumes: operands already selected from the register file
// Notes: no state; the top registers the outputs
`timescale 1ns/10ps
module uh_lanes (
  // operation select
  input wire uh_pkg::uh_op_t op,
  // operands
  input wire logic [uh_pkg::WORD_W-1:0] first_operand,
  input wire logic [uh_pkg::WORD_W-1:0] second_operand,
  // results
  output logic [uh_pkg::WORD_W-1:0] result,
  output logic [uh_pkg::FLAG_W-1:0] greater_equal_flags,
  output logic flags_update
);

  // --------------------------------------------------------------------
  // lane helpers
  // --------------------------------------------------------------------
  // widened by one bit so the carry or borrow lands in the top bit
  function automatic logic [16:0] add17(input logic [15:0] x, input logic [15:0] y);
    add17 = {1'b0, x} + {1'b0, y};
  endfunction : add17

  function automatic logic [16:0] sub17(input logic [15:0] x, input logic [15:0] y);
    sub17 = {1'b0, x} - {1'b0, y};
  endfunction : sub17

  function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y);
    add9 = {1'b0, x} + {1'b0, y};
  endfunction : add9

  function automatic logic [8:0] sub9(input logic [7:0] x, input logic [7:0] y);
    sub9 = {1'b0, x} - {1'b0, y};
  endfunction : sub9

  // --------------------------------------------------------------------
  // lane arithmetic
  // --------------------------------------------------------------------
  logic [15:0] a_hi;
  logic [15:0] a_lo;
  logic [15:0] b_hi;
  logic [15:0] b_lo;
  logic [16:0] hsum_lo;
  logic [16:0] hsum_hi;
  logic [16:0] hdif_lo;
  logic [16:0] hdif_hi;
  logic [16:0] xadd_hi;
  logic [16:0] xsub_lo;
  logic [16:0] xsub_hi;
  logic [16:0] xadd_lo;
  logic [31:0] bsum_half;
  logic [31:0] bdif_half;

  assign a_hi = first_operand[uh_pkg::HALF_HI_POS +: uh_pkg::HALF_W];
  assign a_lo = first_operand[uh_pkg::HALF_LO_POS +: uh_pkg::HALF_W];
  assign b_hi = second_operand[uh_pkg::HALF_HI_POS +: uh_pkg::HALF_W];
  assign b_lo = second_operand[uh_pkg::HALF_LO_POS +: uh_pkg::HALF_W];

  assign hsum_lo = add17(a_lo, b_lo); // RQ6
  assign hsum_hi = add17(a_hi, b_hi); // RQ6
  assign hdif_lo = sub17(a_lo, b_lo); // RQ10
  assign hdif_hi = sub17(a_hi, b_hi); // RQ10
  // exchanged second operand halves
  assign xadd_hi = add17(a_hi, b_lo); // RQ1 RQ5 RQ9
  assign xsub_lo = sub17(a_lo, b_hi); // RQ1 RQ5 RQ9
  assign xsub_hi = sub17(a_hi, b_lo); // RQ12
  assign xadd_lo = add17(a_lo, b_hi); // RQ12

  // each byte lane is independent; no carry crosses a lane boundary
  always_comb begin
    logic [8:0] s;
    logic [8:0] d;
    s = 9'h000;
    d = 9'h000;
    bsum_half = 32'h0000_0000;
    bdif_half = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      s = add9(first_operand[i*8 +: 8], second_operand[i*8 +: 8]); // RQ7 RQ8
      d = sub9(first_operand[i*8 +: 8], second_operand[i*8 +: 8]); // RQ11
      bsum_half[i*8 +: 8] = s[8:1]; // RQ7 RQ8 RQ20
      bdif_half[i*8 +: 8] = d[8:1]; // RQ11 RQ20
    end
  end

  // --------------------------------------------------------------------
  // result select
  // --------------------------------------------------------------------
  always_comb begin
    result = uh_pkg::RST_WORD;
    greater_equal_flags = uh_pkg::RST_FLAGS;
    flags_update = 1'b0;
    unique case (op)
      uh_pkg::unsigned_cross_add_sub: begin
        // same result bits as the signed form; only the flags differ
        result = {xadd_hi[15:0], xsub_lo[15:0]}; // RQ3 RQ5
        greater_equal_flags[3:2] = xadd_hi[16] ? 2'h3 : 2'h0; // RQ2 RQ4
        // a lane that does not borrow is greater or equal
        greater_equal_flags[1:0] = xsub_lo[16] ? 2'h0 : 2'h3; // RQ2 RQ3
        flags_update = 1'b1; // RQ2
      end
      uh_pkg::halving_add_halfword_lanes: result = {hsum_hi[16:1], hsum_lo[16:1]}; // RQ6 RQ20
      uh_pkg::halving_add_byte_lanes: result = bsum_half; // RQ7
      uh_pkg::halving_cross_add_sub: result = {xadd_hi[16:1], xsub_lo[16:1]}; // RQ9 RQ20
      uh_pkg::halving_sub_halfword_lanes: result = {hdif_hi[16:1], hdif_lo[16:1]}; // RQ10 RQ20
      uh_pkg::halving_sub_byte_lanes: result = bdif_half; // RQ11
      uh_pkg::halving_cross_sub_add: result = {xsub_hi[16:1], xadd_lo[16:1]}; // RQ12 RQ20
      uh_pkg::mul_double_accumulate_long: result = uh_pkg::RST_WORD;
    endcase
  end

endmodule : uh_lanes

/* uh_mac.sv */
// Purpose: 32x32 multiply with two 32-bit addends into a 64-bit sum
// Assumes: unsigned operands only
// Notes: the sum cannot overflow 64 bits, so no carry is lost
`timescale 1ns/10ps
module uh_mac (
  // operands
  input wire logic [uh_pkg::WORD_W-1:0] second_operand,
  input wire logic [uh_pkg::WORD_W-1:0] multiplier,
  input wire logic [uh_pkg::WORD_W-1:0] low_accum,
  input wire logic [uh_pkg::WORD_W-1:0] high_accum,
  // result
  output logic [uh_pkg::WORD_W-1:0] low_result,
  output logic [uh_pkg::WORD_W-1:0] high_result
);

  // --------------------------------------------------------------------
  // multiply and double accumulate
  // --------------------------------------------------------------------
  logic [uh_pkg::LONG_W-1:0] product;
  logic [uh_pkg::LONG_W-1:0] total;

  assign product = {32'h0000_0000, second_operand} * {32'h0000_0000, multiplier}; // RQ14
  // max is (2^32-1)^2 + 2*(2^32-1) = 2^64-1, exactly full width
  assign total = product + {32'h0000_0000, low_accum} + {32'h0000_0000, high_accum}; // RQ14
  assign low_result = total[31:0]; // RQ15
  assign high_result = total[63:32]; // RQ15

endmodule : uh_mac

/* uh_alu.sv */
// Purpose: top of the unsigned packed halving datapath, one-cycle registered answer
// Assumes: the decoder presents operand values and the live nzcv flags with each request
// Notes: register numbers never reach this block; register-choice hazards stay with the decoder
//
// Functional notes
// (RQ1) cross add/sub swaps second operand halves
// (RQ2) cross add/sub updates greater-equal flags
// (RQ3) result as signed form, unsigned flags
// (RQ4) add lane carry sets lane flags 11
// (RQ5) upper adds, lower subtracts, both wrap
// (RQ6) halving halfword add keeps sum[16:1]
// (RQ7) halving byte add, four lanes halved
// (RQ8) byte sum nine bits, keep [8:1]
// (RQ9) halving cross add/sub halves both results
// (RQ10) halving halfword subtract keeps diff[16:1]
// (RQ11) halving byte subtract keeps diff[8:1]
// (RQ12) cross sub/add: upper diff, lower sum
// (RQ13) halving operations never touch flags
// (RQ14) multiply plus both accumulators, 64 bits
// (RQ15) low word to low, high to high
// (RQ16) multiply accumulate leaves flags unchanged
// (RQ17) write only when condition passes
// (RQ18) issuer never names the program counter
// (RQ19) issuer keeps both destinations distinct
// (RQ20) truncate after shift, lanes independent
`timescale 1ns/10ps
module uh_alu (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the decoder
  input wire uh_pkg::uh_req_t req,
  // answer to the register file
  output uh_pkg::uh_rsp_t rsp
);

  // --------------------------------------------------------------------
  // condition evaluation
  // --------------------------------------------------------------------
  function automatic logic cond_passed(input logic [3:0] cond, input logic [3:0] nzcv);
    logic n;
    logic z;
    logic c;
    logic v;
    n = nzcv[uh_pkg::FLAG_N_POS];
    z = nzcv[uh_pkg::FLAG_Z_POS];
    c = nzcv[uh_pkg::FLAG_C_POS];
    v = nzcv[uh_pkg::FLAG_V_POS];
    unique case (cond)
      uh_pkg::CC_ZERO_SET: cond_passed = z;
      uh_pkg::CC_ZERO_CLR: cond_passed = !z;
      uh_pkg::CC_CARRY_SET: cond_passed = c;
      uh_pkg::CC_CARRY_CLR: cond_passed = !c;
      uh_pkg::CC_NEG_SET: cond_passed = n;
      uh_pkg::CC_NEG_CLR: cond_passed = !n;
      uh_pkg::CC_OVF_SET: cond_passed = v;
      uh_pkg::CC_OVF_CLR: cond_passed = !v;
      uh_pkg::CC_UNS_HIGHER: cond_passed = c && !z;
      uh_pkg::CC_UNS_LOWER_SAME: cond_passed = !c || z;
      uh_pkg::CC_SIGN_MATCH: cond_passed = (n == v);
      uh_pkg::CC_SIGN_DIFFER: cond_passed = (n != v);
      uh_pkg::CC_SIGNED_ABOVE: cond_passed = !z && (n == v);
      uh_pkg::CC_SIGNED_NOT_ABOVE: cond_passed = z || (n != v);
      uh_pkg::CC_ALWAYS_EXECUTE: cond_passed = 1'b1; // RQ17
      // reserved code is not a conditional form of these operations
      uh_pkg::CC_RESERVED: cond_passed = 1'b0;
    endcase
  endfunction : cond_passed

  // --------------------------------------------------------------------
  // datapath leaves
  // --------------------------------------------------------------------
  logic [uh_pkg::WORD_W-1:0] lane_result;
  logic [uh_pkg::FLAG_W-1:0] lane_flags;
  logic lane_flags_update;
  logic [uh_pkg::WORD_W-1:0] mac_low;
  logic [uh_pkg::WORD_W-1:0] mac_high;

  uh_lanes u_lanes (
    .op(req.op),
    .first_operand(req.first_operand),
    .second_operand(req.second_operand),
    .result(lane_result),
    .greater_equal_flags(lane_flags),
    .flags_update(lane_flags_update)
  );

  uh_mac u_mac (
    .second_operand(req.second_operand),
    .multiplier(req.multiplier),
    .low_accum(req.low_accum),
    .high_accum(req.high_accum),
    .low_result(mac_low),
    .high_result(mac_high)
  );

  // --------------------------------------------------------------------
  // answer register
  // --------------------------------------------------------------------
  uh_pkg::uh_rsp_t next_rsp;
  logic pass;
  logic is_mac;

  assign pass = cond_passed(req.cond, req.nzcv);
  assign is_mac = (req.op == uh_pkg::mul_double_accumulate_long);

  // data fields are held when nothing is written so a failed condition leaves no trace
  always_comb begin
    next_rsp = rsp;
    next_rsp.valid = req.valid;
    next_rsp.executed = req.valid && pass; // RQ17
    next_rsp.wr_low = req.valid && pass; // RQ17
    next_rsp.wr_high = req.valid && pass && is_mac; // RQ15 RQ17
    // halving and multiply forms keep flags untouched
    next_rsp.flags_wr = req.valid && pass && lane_flags_update && !is_mac; // RQ13 RQ16 RQ17
    if (req.valid && pass) begin
      if (is_mac) begin
        next_rsp.low_result = mac_low; // RQ15
        next_rsp.high_result = mac_high; // RQ15
      end else begin
        next_rsp.low_result = lane_result;
      end
      if (lane_flags_update && !is_mac) begin
        next_rsp.greater_equal_flags = lane_flags; // RQ2
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

endmodule : uh_alu

/* uh_alu_monitor.sv */
// Purpose: port checker for the packed halving datapath
// Assumes: one-cycle registered answer, no backpressure
// Notes: prev holds the request taken at the last edge
`timescale 1ns/10ps
module uh_alu_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire uh_pkg::uh_req_t req,
  input wire uh_pkg::uh_rsp_t rsp
);
  uh_pkg::uh_req_t prev;
  logic [63:0] mac;
  logic [16:0] s_hi;
  logic [16:0] s_lo;
  logic halv;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) prev <= '0;
    else prev <= req;
  end
  assign mac = 64'(prev.multiplier) * 64'(prev.second_operand) + 64'(prev.low_accum) + 64'(prev.high_accum);
  assign s_hi = {1'b0, prev.first_operand[31:16]} + {1'b0, prev.second_operand[31:16]};
  assign s_lo = {1'b0, prev.first_operand[15:0]} + {1'b0, prev.second_operand[15:0]};
  assign halv = prev.op != uh_pkg::unsigned_cross_add_sub && prev.op != uh_pkg::mul_double_accumulate_long;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_answer_next: assert property (req.valid |=> rsp.valid)
    else $error("answer missing one cycle after request");
  a_no_stray: assert property (!req.valid |=> !rsp.valid && !rsp.wr_low && !rsp.flags_wr)
    else $error("answer without request");
  a_never_runs: assert property (req.valid && req.cond == 4'hf |=> !rsp.executed && !rsp.wr_low && !rsp.wr_high)
    else $error("failing condition still wrote");
  a_always_runs: assert property (req.valid && req.cond == uh_pkg::CC_ALWAYS_EXECUTE |=> rsp.executed && rsp.wr_low)
    else $error("always condition did not write");
  a_halving_flags: assert property (rsp.valid && halv |-> !rsp.flags_wr)
    else $error("halving operation wrote flags");
  a_flags_held: assert property (!rsp.flags_wr |-> $stable(rsp.greater_equal_flags))
    else $error("flags moved without a flag write");
  a_cross_flags: assert property (rsp.executed && prev.op == uh_pkg::unsigned_cross_add_sub |-> rsp.flags_wr)
    else $error("cross add/sub left flags unwritten");
  a_mac_pair: assert property (rsp.valid && prev.op == uh_pkg::mul_double_accumulate_long |->
    rsp.wr_high == rsp.executed && !rsp.flags_wr && (!rsp.executed || {rsp.high_result, rsp.low_result} == mac))
    else $error("multiply accumulate answer wrong");
  a_hadd_value: assert property (rsp.executed && prev.op == uh_pkg::halving_add_halfword_lanes |->
    rsp.low_result == {s_hi[16:1], s_lo[16:1]})
    else $error("halving halfword add wrong");
  a_data_held: assert property (rsp.valid && !rsp.executed |-> $stable(rsp.low_result))
    else $error("result moved on a skipped request");
endmodule : uh_alu_monitor

bind uh_alu uh_alu_monitor i_mon (.clk(clk), .rst(rst), .req(req), .rsp(rsp));

/* uh_dec_model.sv */
// Purpose: issuing decoder and register file write port model
// Assumes: requests start one small delay after a rising edge
// Notes: writes land in queues so back-to-back answers are all kept
`timescale 1ns/10ps
module uh_dec_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request out, answer in
  output uh_pkg::uh_req_t req,
  input wire uh_pkg::uh_rsp_t rsp
);
  logic [31:0] lo_q[$];
  logic [31:0] hi_q[$];
  logic [3:0] ge_q[$];

  initial req = '0;
  // operand values only: the program counter and equal destinations never reach the block
  task automatic send(input uh_pkg::uh_req_t r);
    @(posedge clk);
    #1 req = r;
  endtask : send
  // idle lines show the inverse, so a stale value is never mistaken for live data
  task automatic idle();
    @(posedge clk);
    #1 req = {1'b0, ~req[$bits(req)-2:0]};
  endtask : idle
  always @(negedge clk) begin
    if (!rst && rsp.wr_low) lo_q.push_back(rsp.low_result);
    if (!rst && rsp.wr_high) hi_q.push_back(rsp.high_result);
    if (!rst && rsp.flags_wr) ge_q.push_back(rsp.greater_equal_flags);
  end
endmodule : uh_dec_model

/* tb.sv */
// Purpose: self-checking bench for the packed halving datapath
// Assumes: answer one cycle after each request
// Notes: expectations come from lane arithmetic written here
`timescale 1ns/10ps
module tb;
  logic clk;
  logic rst;
  uh_pkg::uh_req_t req;
  uh_pkg::uh_rsp_t rsp;
  int num_errors;
  int check_count;
  logic [31:0] pa [4] = '{32'hffff_ffff, 32'h0003_ffff, 32'hffff_0000, 32'h8001_7f80};
  logic [31:0] pb [4] = '{32'hffff_ffff, 32'h0001_0001, 32'h0001_0001, 32'h7fff_8081};

  uh_alu i_dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp));
  uh_dec_model i_dec (.clk(clk), .rst(rst), .req(req), .rsp(rsp));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bytes reuse the halfword helper: bits [8:1] agree whatever the upper bits
  function automatic logic [15:0] h16(input logic [15:0] x, input logic [15:0] y, input logic sub);
    logic [16:0] s;
    s = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    return s[16:1];
  endfunction : h16

  function automatic logic [35:0] lanes(input uh_pkg::uh_op_t op, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] r;
    logic [3:0] ge;
    ge = 4'h0;
    for (int i = 0; i < 4; i++) r[8*i+:8] = 8'(h16(a[8*i+:8], b[8*i+:8], op == uh_pkg::halving_sub_byte_lanes));
    case (op)
      uh_pkg::unsigned_cross_add_sub: begin
        r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
        ge = {{2{17'(a[31:16]) + b[15:0] > 17'hffff}}, {2{a[15:0] >= b[31:16]}}};
      end
      uh_pkg::halving_add_halfword_lanes: r = {h16(a[31:16], b[31:16], 1'b0), h16(a[15:0], b[15:0], 1'b0)};
      uh_pkg::halving_sub_halfword_lanes: r = {h16(a[31:16], b[31:16], 1'b1), h16(a[15:0], b[15:0], 1'b1)};
      uh_pkg::halving_cross_add_sub: r = {h16(a[31:16], b[15:0], 1'b0), h16(a[15:0], b[31:16], 1'b1)};
      uh_pkg::halving_cross_sub_add: r = {h16(a[31:16], b[15:0], 1'b1), h16(a[15:0], b[31:16], 1'b0)};
      default: ;
    endcase
    return {ge, r};
  endfunction : lanes

  function automatic logic passes(input logic [3:0] cc, input logic [3:0] f);
    logic p;
    case (cc[3:1])
      3'h0: p = f[2];
      3'h1: p = f[1];
      3'h2: p = f[3];
      3'h3: p = f[0];
      3'h4: p = f[1] & ~f[2];
      3'h5: p = f[3] == f[0];
      3'h6: p = ~f[2] & (f[3] == f[0]);
      default: p = 1'b1;
    endcase
    return p ^ cc[0];
  endfunction : passes

  function automatic uh_pkg::uh_req_t mk(input uh_pkg::uh_op_t op, input logic [3:0] cc,
                                         input logic [31:0] a, input logic [31:0] b);
    return '{1'b1, op, cc, 4'h0, a, b, 32'h0, 32'h0, 32'h0};
  endfunction : mk

  task automatic settle();
    i_dec.idle();
    repeat (2) @(posedge clk);
  endtask : settle

  task automatic t_lanes();
    logic [35:0] e;
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 4; j++) begin
        e = lanes(uh_pkg::uh_op_t'(k), pa[j], pb[j]);
        i_dec.send(mk(uh_pkg::uh_op_t'(k), uh_pkg::CC_ALWAYS_EXECUTE, pa[j], pb[j]));
        settle();
        chk(i_dec.lo_q.size(), 1);
        chk(i_dec.lo_q.pop_front(), e[31:0]);
        chk(i_dec.ge_q.size(), k == 0);
        if (k == 0) chk(i_dec.ge_q.pop_front(), e[35:32]);
      end
    end
  endtask : t_lanes

  task automatic t_back2back();
    i_dec.send(mk(uh_pkg::unsigned_cross_add_sub, uh_pkg::CC_ALWAYS_EXECUTE, 32'hffff_0000, 32'h0001_0001));
    i_dec.send(mk(uh_pkg::halving_add_byte_lanes, uh_pkg::CC_ALWAYS_EXECUTE, 32'h01ff_80fe, 32'h03ff_8002));
    settle();
    chk(i_dec.lo_q.pop_front(), 32'h0000_ffff);
    chk(i_dec.ge_q.pop_front(), 4'hc);
    chk(i_dec.lo_q.pop_front(), 32'h02ff_8080);
  endtask : t_back2back

  task automatic mac_case(input logic [31:0] b, input logic [31:0] m, input logic [31:0] lo, input logic [31:0] hi);
    uh_pkg::uh_req_t r;
    logic [63:0] e;
    e = 64'(b) * 64'(m) + 64'(lo) + 64'(hi);
    r = mk(uh_pkg::mul_double_accumulate_long, uh_pkg::CC_ALWAYS_EXECUTE, 32'h0, b);
    r.multiplier = m;
    r.low_accum = lo;
    r.high_accum = hi;
    i_dec.send(r);
    settle();
    chk({i_dec.hi_q.pop_front(), i_dec.lo_q.pop_front()}, e);
    chk(i_dec.ge_q.size(), 0);
  endtask : mac_case

  task automatic t_cond();
    uh_pkg::uh_req_t r;
    for (int c = 0; c < 16; c++) begin
      for (int n = 0; n < 16; n += 5) begin
        r = mk(uh_pkg::halving_add_halfword_lanes, 4'(c), 32'h0003_ffff, 32'h0001_0001);
        r.nzcv = 4'(n);
        i_dec.send(r);
        settle();
        chk(i_dec.lo_q.size(), passes(4'(c), 4'(n)));
        if (i_dec.lo_q.size() != 0) chk(i_dec.lo_q.pop_front(), 32'h0002_8000);
      end
    end
    // a skipped multiply must write neither half
    r = mk(uh_pkg::mul_double_accumulate_long, uh_pkg::CC_ZERO_SET, 32'h0000_0000, 32'h0000_0003);
    r.multiplier = 32'h0000_0005;
    i_dec.send(r);
    settle();
    chk(i_dec.lo_q.size() + i_dec.hi_q.size(), 0);
  endtask : t_cond

  // reset lands while an answer stands; the first request after release must still work
  task automatic t_reset();
    i_dec.send(mk(uh_pkg::halving_add_halfword_lanes, uh_pkg::CC_ALWAYS_EXECUTE, 32'h0003_ffff, 32'h0001_0001));
    @(posedge clk);
    #1 rst = 1'b1;
    #1 chk(|rsp, 1'b0);
    i_dec.idle();
    @(posedge clk);
    #1 rst = 1'b0;
    i_dec.lo_q.delete();
    i_dec.send(mk(uh_pkg::halving_add_halfword_lanes, uh_pkg::CC_ALWAYS_EXECUTE, 32'hffff_ffff, 32'h0001_0001));
    settle();
    chk(i_dec.lo_q.pop_front(), 32'h8000_8000);
  endtask : t_reset

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst = 1'b1;
    num_errors = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_lanes();
    t_back2back();
    mac_case(32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff);
    mac_case(32'h0001_0000, 32'h0001_0000, 32'h8000_0000, 32'h8000_0000);
    t_cond();
    t_reset();
    report_and_stop();
  end

  // the run needs about 400 cycles
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule : tb
